//--- rtl/pswd_top.sv
/*
 pswd_top: pin-selectable watchdog supervisor with selectable timeout and startup delay (delay fixed in group b).
 assumes select and kick pins are asynchronous; fault output is active low.
*/
`timescale 1ns/1ps
module pswd_top
   import pswd_pkg::*;
#(
   parameter logic [1:0] VARIANT_GRP = pswd_pkg::GRP_A,
   parameter bit         PUSH_PULL   = 1'b0
)
(
   input  wire logic       CORE_CLK,
   input  wire logic       ARST_N,
   input  wire logic       KICK_IN,
   input  wire logic       TIMING_SEL0,
   input  wire logic       TIMING_SEL1,
   input  wire logic       TIMING_SEL2,
   output logic            FAULT_PULSE_N
);
   import pswd_pkg::*;

   typedef struct packed {
      pswd_state_t      state;
      logic [PRE_W-1:0] pre;
      logic             tick;
      logic [CNT_W-1:0] cnt;
      logic [2:0]       sel;
      logic             kick;
      logic             fault_n;
   } pswd_core_t;

   pswd_core_t st_r;
   pswd_core_t st_nxt;
   pswd_pins_t pins_raw;
   pswd_pins_t pins_s;

   assign pins_raw = '{sel: {TIMING_SEL2, TIMING_SEL1, TIMING_SEL0}, kick: KICK_IN};

   pswd_sync #(.W($bits(pswd_pins_t))) u_sync
   (
      .CORE_CLK (CORE_CLK),
      .ARST_N   (ARST_N),
      .d        (pins_raw),
      .q        (pins_s)
   );

   logic             kick_edge;
   logic             sel_chg;
   logic [CNT_W-1:0] to_ticks;
   logic [CNT_W-1:0] dly_ticks;
   logic [CNT_W-1:0] pulse_ticks;
   logic             first_edge_mode;

   assign to_ticks    = us_to_ticks(timeout_min_us(VARIANT_GRP, st_r.sel));
   assign dly_ticks   = us_to_ticks(delay_min_us(VARIANT_GRP, st_r.sel));
   assign pulse_ticks = us_to_ticks(PUSH_PULL ? PULSE_PP_US : PULSE_OD_US);
   assign first_edge_mode = (VARIANT_GRP == GRP_C) && (dly_ticks == '0);
   assign kick_edge   = pins_s.kick != st_r.kick;
   assign sel_chg     = pins_s.sel != st_r.sel;

   always_comb
   begin
      st_nxt      = st_r;
      st_nxt.kick = pins_s.kick;
      st_nxt.sel  = pins_s.sel;
      st_nxt.tick = 1'b0;
      if (st_r.pre == PRE_LAST)
      begin
         st_nxt.pre  = '0;
         st_nxt.tick = 1'b1;
      end
      else
         st_nxt.pre = st_r.pre + 1'b1;
      if (st_r.tick && st_r.cnt != '0)
         st_nxt.cnt = st_r.cnt - 1'b1;
      if (sel_chg && st_r.state != ST_FAULT)
      begin
         st_nxt.state   = ST_SETUP;
         st_nxt.cnt     = IGNORE_TICKS;
         st_nxt.fault_n = 1'b1;
      end
      else
      begin
         case (st_r.state)
            ST_SETUP:
            begin
               // kick edges here are ignored on purpose
               if (st_r.cnt == '0)
               begin
                  if (st_r.sel == SEL_DISABLE)
                     st_nxt.state = ST_OFF;
                  else if (first_edge_mode)
                     st_nxt.state = ST_EDGE;
                  else
                  begin
                     st_nxt.state = ST_DELAY;
                     st_nxt.cnt   = dly_ticks;
                  end
               end
            end
            ST_DELAY:
            begin
               if (st_r.cnt == '0)
               begin
                  st_nxt.state = ST_WATCH;
                  st_nxt.cnt   = to_ticks;
               end
            end
            ST_EDGE:
            begin
               if (kick_edge)
               begin
                  st_nxt.state = ST_WATCH;
                  st_nxt.cnt   = to_ticks;
               end
            end
            ST_WATCH:
            begin
               if (kick_edge)
                  st_nxt.cnt = to_ticks;
               else if (st_r.cnt == '0)
               begin
                  st_nxt.state   = ST_FAULT;
                  st_nxt.cnt     = pulse_ticks;
                  st_nxt.fault_n = 1'b0;
               end
            end
            ST_FAULT:
            begin
               // timer counts down the pulse length; kicks cannot restart it
               if (st_r.cnt == '0)
               begin
                  st_nxt.fault_n = 1'b1;
                  st_nxt.state   = ST_SETUP;
                  st_nxt.cnt     = IGNORE_TICKS;
               end
            end
            ST_OFF:
               st_nxt.fault_n = 1'b1;
            default:
            begin
               st_nxt.state   = ST_SETUP;
               st_nxt.cnt     = IGNORE_TICKS;
               st_nxt.fault_n = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
      begin
         st_r.state   <= ST_SETUP;
         st_r.pre     <= '0;
         st_r.tick    <= 1'b0;
         st_r.cnt     <= IGNORE_TICKS;
         st_r.sel     <= '0;
         st_r.kick    <= 1'b0;
         st_r.fault_n <= 1'b1;
      end
      else
         st_r <= st_nxt;
   end

   assign FAULT_PULSE_N = st_r.fault_n;

   a_off_quiet: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      st_r.state == ST_OFF |-> st_r.fault_n)
      else $error("fault asserted while disabled");
   a_fault_state: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      !st_r.fault_n |-> st_r.state == ST_FAULT)
      else $error("fault low outside fault state");
   a_kick_reload: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      st_r.state == ST_WATCH && kick_edge && !sel_chg |=> st_r.cnt == $past(to_ticks))
      else $error("kick did not reload timer");
   a_expire_fault: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      st_r.state == ST_WATCH && st_r.cnt == '0 && !kick_edge && !sel_chg
      |=> !st_r.fault_n && st_r.cnt == pulse_ticks)
      else $error("expiry did not start pulse");
   a_pulse_end: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      $rose(st_r.fault_n) |-> st_r.state == ST_SETUP && st_r.cnt == IGNORE_TICKS)
      else $error("no setup interval after pulse");
   a_sel_restart: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      sel_chg && st_r.state != ST_FAULT |=> st_r.state == ST_SETUP)
      else $error("select change did not restart");
   a_edge_wait: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      st_r.state == ST_EDGE && !kick_edge && !sel_chg |=> st_r.state == ST_EDGE)
      else $error("first-edge wait left without edge");
   a_tick_rate: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      st_r.tick |=> !st_r.tick [*8])
      else $error("prescaler tick too frequent");
   // kicks landing in the setup interval must not end it early
   a_setup_ignore: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      st_r.state == ST_SETUP && st_r.cnt != '0 && kick_edge && !sel_chg
      |=> st_r.state == ST_SETUP)
      else $error("kick ended setup interval");
   a_delay_hold: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      st_r.state == ST_DELAY && st_r.cnt != '0 && !sel_chg |=> st_r.state == ST_DELAY)
      else $error("startup delay cut short");
   a_pulse_hold: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      st_r.state == ST_FAULT && st_r.cnt != '0 |=> st_r.state == ST_FAULT && !st_r.fault_n)
      else $error("fault pulse cut short");
   a_off_stays: assert property (@(posedge CORE_CLK) disable iff (!ARST_N)
      st_r.state == ST_OFF && !sel_chg |=> st_r.state == ST_OFF)
      else $error("disabled watchdog restarted");
endmodule

//--- include/pswd_pkg.sv
/*
 pswd_pkg: constants, timing tables and state types for the pin-selectable watchdog.
 assumes a 25 MHz core clock and a 1 us prescaler tick.
*/
package pswd_pkg;
   localparam int unsigned CLK_HZ        = 25_000_000;
   localparam int unsigned TICK_US       = 1;
   // prescaler: cycles per microsecond tick
   localparam int unsigned TICK_CYC      = CLK_HZ / 1_000_000 * TICK_US;
   localparam int          PRE_W         = 5;
   localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYC - 1);
   localparam int          CNT_W         = 28;

   localparam logic [1:0]  GRP_A         = 2'h0;
   localparam logic [1:0]  GRP_B         = 2'h1;
   localparam logic [1:0]  GRP_C         = 2'h2;
   localparam logic [2:0]  SEL_DISABLE   = 3'h3;

   // times in microseconds, KICK_MIN_WIDTH_NS in ns; us_to_ticks counts are twice the minimum, inside min..3*min; IGNORE_TICKS is half
   localparam int unsigned KICK_IGNORE_US = 300;
   localparam int unsigned MARGIN_NUM     = 2;
   localparam int unsigned PULSE_OD_US    = 100_000;
   localparam int unsigned PULSE_PP_US    = 1_000;
   localparam int unsigned B_DELAY_US     = 60_000_000;
   localparam int unsigned KICK_MIN_WIDTH_NS = 100;

   localparam logic [CNT_W-1:0] IGNORE_TICKS =
      CNT_W'((KICK_IGNORE_US / 2) / TICK_US);

   function automatic logic [CNT_W-1:0] us_to_ticks(input int unsigned us);
      us_to_ticks = CNT_W'(us * MARGIN_NUM / TICK_US);
   endfunction

   // minimum timeout per select code, microseconds; code 3 unused
   function automatic int unsigned timeout_min_us(input logic [1:0] grp,
                                                  input logic [2:0] sel);
      int unsigned a [8];
      int unsigned b [8];
      int unsigned c [8];
      a = '{1_000, 10_000, 30_000, 0, 100_000, 1_000_000, 10_000_000, 60_000_000};
      b = '{1_000, 3_000, 10_000, 0, 100_000, 300_000, 3_000_000, 60_000_000};
      c = '{3_000, 3_000, 1_000_000, 0, 30, 1_000_000, 10_000_000, 10_000_000};
      case (grp)
         GRP_A:   timeout_min_us = a[sel];
         GRP_B:   timeout_min_us = b[sel];
         default: timeout_min_us = c[sel];
      endcase
   endfunction

   // minimum startup delay; zero in group c means first-edge wait
   function automatic int unsigned delay_min_us(input logic [1:0] grp,
                                                input logic [2:0] sel);
      int unsigned c [8];
      c = '{3_000, 3_000, 60_000_000, 0, 200, 0, 0, 60_000_000};
      case (grp)
         GRP_A:   delay_min_us = timeout_min_us(grp, sel);
         GRP_B:   delay_min_us = B_DELAY_US;
         default: delay_min_us = c[sel];
      endcase
   endfunction

   typedef enum logic [2:0] {
      ST_SETUP = 3'b000,
      ST_DELAY = 3'b001,
      ST_EDGE  = 3'b010,
      ST_WATCH = 3'b011,
      ST_FAULT = 3'b100,
      ST_OFF   = 3'b101
   } pswd_state_t;

   typedef struct packed {
      logic [2:0] sel;
      logic       kick;
   } pswd_pins_t;
endpackage

//--- rtl/pswd_sync.sv
/*
 pswd_sync: two-flop synchroniser for asynchronous pins.
 assumes one clock and an asynchronous active-low reset.
*/
`timescale 1ns/1ps
module pswd_sync
#(
   parameter int W = 4
)
(
   input  wire logic         CORE_CLK,
   input  wire logic         ARST_N,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } pswd_sync_t;

   pswd_sync_t st_r;
   pswd_sync_t st_nxt;

   always_comb
   begin
      st_nxt    = st_r;
      st_nxt.s1 = d;
      st_nxt.s2 = st_r.s1;
   end

   always_ff @(posedge CORE_CLK or negedge ARST_N)
   begin
      if (!ARST_N)
         st_r <= '0;
      else
         st_r <= st_nxt;
   end

   assign q = st_r.s2;
endmodule

//--- verif/pswd_kicker.sv
/*
 pswd_kicker: model of the supervised processor toggling the kick pin.
 assumes the bench clock; toggles every 500 cycles (20 us) while run is high.
*/
`timescale 1ns/1ps
module pswd_kicker
(
   input  wire logic CORE_CLK,
   input  wire logic run,
   output logic      kick
);
   int   cnt    = 0;
   logic kick_r = 1'b0;
   // each level is held 20 us, far above the 100 ns minimum and below any timeout
   always @(posedge CORE_CLK)
   begin
      if (!run)
         cnt <= 0;
      else if (cnt == 499)
      begin
         cnt  <= 0;
         kick_r <= ~kick_r;
      end
      else
         cnt <= cnt + 1;
   end

   assign kick = kick_r;
endmodule

//--- verif/tb_pswd_top.sv
/*
 tb_pswd_top: self-checking bench for the watchdog, group c, push-pull pulse.
 assumes 25 MHz clock; code 100 gives short delay and timeout counts.
*/
`timescale 1ns/1ps
module tb_pswd_top;
   import pswd_pkg::*;
   logic       core_clk = 1'b0;
   logic       arst_n   = 1'b0;
   logic [2:0] sel      = 3'h4;
   logic       run      = 1'b0;
   logic       kick;
   logic       fault_n;
   int         bad_count   = 0;
   int         comparisons = 0;
   int         cycles      = 0;

   always #20 core_clk = ~core_clk;

   pswd_top #(.VARIANT_GRP(GRP_C), .PUSH_PULL(1'b1)) dut
   (
      .CORE_CLK      (core_clk),
      .ARST_N        (arst_n),
      .KICK_IN       (kick),
      .TIMING_SEL0   (sel[0]),
      .TIMING_SEL1   (sel[1]),
      .TIMING_SEL2   (sel[2]),
      .FAULT_PULSE_N (fault_n)
   );

   pswd_kicker kicker
   (
      .CORE_CLK (core_clk),
      .run      (run),
      .kick     (kick)
   );

   task automatic end_sim();
      if (bad_count == 0 && comparisons > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // hang guard: whole run is near 97k cycles
   always @(posedge core_clk)
   begin
      cycles <= cycles + 1;
      if (cycles == 110000)
      begin
         bad_count = bad_count + 1;
         end_sim();
      end
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
         bad_count = bad_count + 1;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // counts cycles until the fault pin shows lvl, bounded
   task automatic wait_lvl(input logic lvl, output int n);
      n = 0;
      while (fault_n !== lvl && n < 80000)
      begin
         @(posedge core_clk);
         #1;
         n++;
      end
   endtask

   // reports whether the fault pin went low within n cycles
   task automatic watch(input int n, output logic low);
      low = 1'b0;
      repeat (n)
      begin
         @(posedge core_clk);
         #1;
         if (fault_n !== 1'b1)
            low = 1'b1;
      end
   endtask

   // no kicks: fault after setup + delay (200..600 us) + timeout (30..90 us)
   task automatic t_first_fault();
      int n;
      wait_lvl(1'b0, n);
      check({31'h0, n >= 5750 && n <= 24800}, 32'h1);
      wait_lvl(1'b1, n);
      check({31'h0, n >= 25000 && n <= 75050}, 32'h1);
      check({31'h0, fault_n}, 32'h1);
   endtask

   // steady kicks after the pulse keep the output high through startup and watch
   task automatic t_kick_keeps();
      logic low;
      @(posedge core_clk);
      run <= 1'b1;
      watch(24000, low);
      check({31'h0, low}, 32'h0);
   endtask

   // disable code: kicks running, then stopped; a kick must not wake a zero timeout
   task automatic t_disable();
      logic low;
      @(posedge core_clk);
      sel <= SEL_DISABLE;
      watch(5000, low);
      check({31'h0, low}, 32'h0);
      @(posedge core_clk);
      run <= 1'b0;
      watch(3000, low);
      check({31'h0, low}, 32'h0);
   endtask

   initial
   begin
      repeat (8) @(posedge core_clk);
      arst_n <= 1'b1;
      #1;
      check({31'h0, fault_n}, 32'h1);
      t_first_fault();
      t_kick_keeps();
      t_disable();
      end_sim();
   end
endmodule
